// *** shared/usr_pkg.sv ***
// package: register map, field positions, reset values and states of the block
// Function
// [RULE1] host endpoint access sets flag; gated interrupt
// [RULE2] firmware clears serviced flag by writing zero
// [RULE3] flags in bits 0-3, upper bits zero
// [RULE4] three-bit field selects endpoint FIFO, reset 000
// [RULE5] unimplemented endpoint selection gives no FIFO
// [RULE6] bit 3 gates the bus clock
// [RULE7] firmware sets deep suspend only in halt
// [RULE8] bit 5 picks PLL core clock, reset oscillator
// [RULE9] bit 6 one for 6MHz crystal, reset 12MHz
// [RULE10] bit 7 connects D+ pull-up resistor
// [RULE11] address register bit 0 enables remote wake
// [RULE12] address bits 1-7, register resets 00H
// [RULE13] firmware writes address after SETUP stage completes
// [RULE14] firmware sets halt bit on endpoint misbehaviour
// [RULE15] bus reset clears halts; setup clears endpoint 0
// [RULE16] deferred update applies address after IN read
// [RULE17] respond only to tokens matching active address
package usr_pkg;
  localparam logic [3:0] OFS_FLAGS  = 4'h0;
  localparam logic [3:0] OFS_UCC    = 4'h4;
  localparam logic [3:0] OFS_ADDR   = 4'h8;
  localparam logic [3:0] OFS_HALT   = 4'hC;
  localparam logic [5:0] OFS_MASK   = 6'h10;
  localparam logic [5:0] OFS_AUTO   = 6'h14;
  localparam logic [5:0] OFS_SEL_ST = 6'h18;
  localparam int UCC_SEL_LSB   = 0;
  localparam int UCC_CLK_BIT   = 3;
  localparam int UCC_SUSP_BIT  = 4;
  localparam int UCC_PLL_BIT   = 5;
  localparam int UCC_XTAL_BIT  = 6;
  localparam int UCC_RES_BIT   = 7;
  localparam int ADDR_WAKE_BIT = 0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] UCC_RST   = 8'h00;
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] HALT_RST  = 8'h00;
  localparam logic [3:0] MASK_RST  = 4'h0;
  localparam logic [2:0] NUM_EP_SEL = 3'h3; // highest implemented endpoint
  typedef enum logic [1:0] {
    USR_IDLE = 2'b01,
    USR_WAIT = 2'b10
  } usr_bus_e;
endpackage

// *** rtl/usr_sie_regs.sv ***
// design: control and status registers of the full-speed serial engine
`timescale 1ns/1ps
module usr_sie_regs
  import usr_pkg::*;
#(
  parameter int NUM_EP = 4
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // avalon-mm slave
  input  wire logic [5:0] i_address,
  input  wire logic       i_read,
  input  wire logic       i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0] i_byteenable,
  output logic [31:0]     o_readdata,
  output logic            o_waitrequest,
  // engine side events
  input  wire logic       i_tok_valid,
  input  wire logic [6:0] i_tok_addr,
  input  wire logic [1:0] i_tok_ep,
  input  wire logic       i_tok_setup,
  input  wire logic       i_in_done,
  input  wire logic       i_bus_reset,
  input  wire logic       i_stack_full,
  // controls
  output logic            o_irq,
  output logic            o_tok_accept,
  output logic [6:0]      o_active_addr,
  output logic [2:0]      o_fifo_sel,
  output logic            o_fifo_sel_valid,
  output logic            o_bus_clock_gate,
  output logic            o_deep_suspend_power_save,
  output logic            o_pll_core_clock_select,
  output logic            o_crystal_rate_select,
  output logic            o_dplus_resistor_connect,
  output logic            o_remote_wake_allow,
  output logic [3:0]      o_endpoint_halt_bits
);

  // map summary; every register sits in the low byte of its word:
  //   0x00 endpoint access flags in bits 3:0, write zero to clear
  //   0x04 fifo select, clock gate, suspend, clock source, pull-up
  //   0x08 device address in bits 7:1, remote wake enable in bit 0
  //   0x0C endpoint halt bits in bits 3:0
  //   0x10 interrupt enable mask, one bit per endpoint
  //   0x14 deferred address mode in bit 0, pending flag in bit 1
  //   0x18 address the engine currently answers to, read only
  // everything else reads as zero and ignores writes
  //
  // the mask stands in for the shared interrupt enable: a flag only
  // requests an interrupt while its mask bit is set
  //
  // each group below has one combinational process (three for the flags) for its
  // next values and one clocked process that only registers them, so
  // the groups can be read, changed and reset on their own

  // endpoint access flags and their interrupt mask
  logic [3:0]  flags_reg;
  logic [3:0]  flags_next;
  logic [3:0]  mask_reg;
  logic [3:0]  mask_next;
  logic        irq_reg;
  logic        irq_next;

  // clock, suspend and fifo selection byte
  logic [7:0]  ucc_reg;
  logic [7:0]  ucc_next;
  logic        sel_ok_reg;
  logic        sel_ok_next;

  // address, wake enable and the deferred update machinery
  logic [7:0]  addr_reg;
  logic [7:0]  addr_next;
  logic        auto_reg;
  logic        auto_next;
  logic        pend_reg;
  logic        pend_next;
  logic [6:0]  act_reg;
  logic [6:0]  act_next;

  // endpoint halt bits
  logic [3:0]  halt_reg;
  logic [3:0]  halt_next;

  // token acceptance pulse
  logic        acc_reg;
  logic        acc_next;

  // register bus handshake
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        wait_reg;
  logic        wait_next;
  usr_bus_e    st_reg;
  usr_bus_e    st_next;

  // decoded strobes shared by the groups below
  logic        wr_go;
  logic        hit;
  logic [3:0]  ep_set;
  logic [7:0]  wd;
  logic        wr_flags;
  logic        wr_ucc;
  logic        wr_addr;
  logic        wr_halt;
  logic        wr_mask;
  logic        wr_auto;

  // write data lives in the low byte; upper lanes are not decoded
  assign wd       = i_writedata[7:0];

  // a write lands in the acknowledge cycle only, one access per
  // handshake; a write without the low byte lane enabled is dropped
  assign wr_go    = (st_reg == USR_WAIT) && i_write && i_byteenable[0];

  // one strobe per writable register
  assign wr_flags = wr_go && (i_address == {2'b00, OFS_FLAGS});
  assign wr_ucc   = wr_go && (i_address == {2'b00, OFS_UCC});
  assign wr_addr  = wr_go && (i_address == {2'b00, OFS_ADDR});
  assign wr_halt  = wr_go && (i_address == {2'b00, OFS_HALT});
  assign wr_mask  = wr_go && (i_address == OFS_MASK);
  assign wr_auto  = wr_go && (i_address == OFS_AUTO);

  // a token counts only when its address field matches the address in
  // effect, so traffic for a neighbour touches none of our state but a pending address, which any IN completion applies
  assign hit = i_tok_valid && (i_tok_addr == act_reg); // RULE17

  // one access decoder per endpoint; the token's endpoint number picks
  // the flag that the hit lands on
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      assign ep_set[g] = hit && (i_tok_ep == 2'(g)); // RULE1
    end
  endgenerate

  // flags: firmware clears by writing zero, hardware sets; a set in the
  // same cycle as the clear wins, so no endpoint access is ever lost
  always_comb begin
    flags_next = flags_reg;
    if (wr_flags) begin
      flags_next = flags_reg & wd[3:0]; // RULE2
    end
    flags_next = flags_next | ep_set; // RULE1
  end

  // mask: plain read and write, one enable per endpoint
  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next = wd[3:0];
    end
  end

  // interrupt: a level one cycle behind the flags; held off while the
  // call stack is full, since the core could not take the vector then
  always_comb begin
    irq_next = (|(flags_reg & mask_reg)) && !i_stack_full; // RULE1
  end

  // flags, mask and interrupt registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      flags_reg <= FLAGS_RST[3:0]; // RULE3
      mask_reg  <= MASK_RST;
      irq_reg   <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
      irq_reg   <= irq_next;
    end
  end

  // clock and selection byte; the select validity is registered with
  // it so the valid output comes from a flop and never glitches
  always_comb begin
    ucc_next = ucc_reg;
    if (wr_ucc) begin
      ucc_next = wd;
    end
    // codes above the highest endpoint reach no fifo at all
    sel_ok_next = (ucc_next[UCC_SEL_LSB +: 3] <= NUM_EP_SEL); // RULE5
  end

  // clock and selection registers; code 000 after reset is valid
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ucc_reg    <= UCC_RST; // RULE4
      sel_ok_reg <= 1'b1;
    end else begin
      ucc_reg    <= ucc_next;
      sel_ok_reg <= sel_ok_next;
    end
  end

  // address: a direct write takes effect at once; in deferred mode the
  // byte is parked and applied when the host completes an IN read, so
  // the status stage of an address change still answers on the old one
  always_comb begin
    addr_next = addr_reg;
    auto_next = auto_reg;
    pend_next = pend_reg;
    act_next  = act_reg;
    if (wr_auto) begin
      auto_next = wd[0];
    end
    if (wr_addr) begin
      addr_next = wd; // RULE11 RULE12
      if (auto_reg) begin
        pend_next = 1'b1; // RULE16
      end else begin
        act_next = wd[7:1]; // RULE16
      end
    end
    // limitation: an IN completion in the cycle of a deferred write, with an
    // update already pending, applies the byte held before that write
    if (pend_reg && i_in_done) begin
      act_next  = addr_reg[7:1]; // RULE16
      pend_next = 1'b0;
    end
  end

  // address registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= ADDR_RST; // RULE12
      auto_reg <= 1'b0;
      pend_reg <= 1'b0;
      act_reg  <= 7'h00;
    end else begin
      addr_reg <= addr_next;
      auto_reg <= auto_next;
      pend_reg <= pend_next;
      act_reg  <= act_next;
    end
  end

  // halt bits: firmware sets them; a setup token for us clears
  // endpoint 0 and a bus reset clears all four, winning over any write
  always_comb begin
    halt_next = halt_reg;
    if (wr_halt) begin
      halt_next = wd[3:0];
    end
    if (hit && i_tok_setup) begin
      halt_next[0] = 1'b0; // RULE15
    end
    if (i_bus_reset) begin
      halt_next = 4'h0; // RULE15
    end
  end

  // halt register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      halt_reg <= HALT_RST[3:0];
    end else begin
      halt_reg <= halt_next;
    end
  end

  // token accept: a one-cycle pulse the cycle after a matching token
  always_comb begin
    acc_next = hit; // RULE17
  end

  // token accept register
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      acc_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // bus handshake: a request is taken on an idle edge, waitrequest is
  // low for the one cycle that follows and the master sees it low at
  // the next edge; read data are loaded on the taking edge so they
  // stand at that acknowledge edge and until the next read
  always_comb begin
    st_next = st_reg;
    rd_next = rd_reg;
    case (st_reg)
      USR_IDLE: begin
        if (i_read || i_write) begin
          st_next = USR_WAIT;
        end
        if (i_read) begin
          case (i_address)
            {2'b00, OFS_FLAGS}: begin
              rd_next = {28'h000_0000, flags_reg}; // RULE3
            end
            {2'b00, OFS_UCC}: begin
              rd_next = {24'h00_0000, ucc_reg};
            end
            {2'b00, OFS_ADDR}: begin
              rd_next = {24'h00_0000, addr_reg};
            end
            {2'b00, OFS_HALT}: begin
              rd_next = {28'h000_0000, halt_reg};
            end
            OFS_MASK: begin
              rd_next = {28'h000_0000, mask_reg};
            end
            OFS_AUTO: begin
              rd_next = {30'h0000_0000, pend_reg, auto_reg};
            end
            OFS_SEL_ST: begin
              rd_next = {25'h000_0000, act_reg};
            end
            default: begin
              rd_next = 32'h0000_0000;
            end
          endcase
        end
      end
      USR_WAIT: begin
        st_next = USR_IDLE;
      end
      default: begin
        st_next = USR_IDLE;
      end
    endcase
    // waitrequest is registered from the next state, so it is high in
    // every idle cycle and low only in the acknowledge cycle
    wait_next = (st_next == USR_IDLE);
  end

  // bus registers
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rd_reg   <= 32'h0000_0000;
      wait_reg <= 1'b1;
      st_reg   <= USR_IDLE;
    end else begin
      rd_reg   <= rd_next;
      wait_reg <= wait_next;
      st_reg   <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign o_irq            = irq_reg;
  assign o_tok_accept     = acc_reg; // RULE17
  assign o_active_addr    = act_reg;
  assign o_readdata       = rd_reg;
  assign o_waitrequest    = wait_reg;
  assign o_fifo_sel       = ucc_reg[UCC_SEL_LSB +: 3]; // RULE4
  assign o_fifo_sel_valid = sel_ok_reg; // RULE5

  // control bits go to the clock, power and pull-up logic as they are
  assign o_bus_clock_gate          = ucc_reg[UCC_CLK_BIT]; // RULE6
  assign o_deep_suspend_power_save = ucc_reg[UCC_SUSP_BIT];
  assign o_pll_core_clock_select   = ucc_reg[UCC_PLL_BIT]; // RULE8
  assign o_crystal_rate_select     = ucc_reg[UCC_XTAL_BIT]; // RULE9
  assign o_dplus_resistor_connect  = ucc_reg[UCC_RES_BIT]; // RULE10
  assign o_remote_wake_allow       = addr_reg[ADDR_WAKE_BIT]; // RULE11
  assign o_endpoint_halt_bits      = halt_reg; // RULE14

endmodule

// *** verification/usr_sie_chk.sv ***
// checker: port assertions for the serial engine registers
`timescale 1ns/1ps
module usr_sie_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_write,
  input wire logic       i_tok_valid,
  input wire logic [6:0] i_tok_addr,
  input wire logic       i_in_done,
  input wire logic       i_bus_reset,
  input wire logic       i_stack_full,
  input wire logic       o_irq,
  input wire logic       o_tok_accept,
  input wire logic [6:0] o_active_addr,
  input wire logic [2:0] o_fifo_sel,
  input wire logic       o_fifo_sel_valid,
  input wire logic       o_bus_clock_gate,
  input wire logic [3:0] o_endpoint_halt_bits
);
  // one domain, so clock and reset are given once
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire hit = i_tok_valid && i_tok_addr == o_active_addr;
  irq_block_a: assert property ($past(i_stack_full) |-> !o_irq)
    else $error("irq with stack full");
  tok_skip_a: assert property (i_tok_valid && !hit |=> !o_tok_accept)
    else $error("foreign token taken");
  tok_take_a: assert property (hit |=> o_tok_accept)
    else $error("own token missed");
  halt_reset_a: assert property (
    i_bus_reset |=> !(|o_endpoint_halt_bits))
    else $error("halt kept over bus reset");
  sel_range_a: assert property (
    o_fifo_sel_valid == (o_fifo_sel <= 3'h3))
    else $error("fifo select validity wrong");
  clk_hold_a: assert property (!i_write |=> $stable(o_bus_clock_gate))
    else $error("clock gate moved alone");
  addr_cause_a: assert property (o_active_addr != $past(o_active_addr)
    |-> $past(i_write) || $past(i_in_done) || $past(i_bus_reset))
    else $error("address changed alone");
  halt_cause_a: assert property ((o_endpoint_halt_bits
    & ~$past(o_endpoint_halt_bits)) != 4'h0 |-> $past(i_write))
    else $error("halt set without write");
endmodule
bind usr_sie_regs usr_sie_chk usr_sie_chk_inst (.i_mclk, .i_rst, .i_write,
  .i_tok_valid, .i_tok_addr, .i_in_done, .i_bus_reset, .i_stack_full, .o_irq,
  .o_tok_accept, .o_active_addr, .o_fifo_sel, .o_fifo_sel_valid,
  .o_bus_clock_gate, .o_endpoint_halt_bits);

// *** verification/usr_host_model.sv ***
// partner: host side token source
`timescale 1ns/1ps
module usr_host_model (
  input  wire logic  i_mclk,
  output logic       o_tok_valid,
  output logic [6:0] o_tok_addr,
  output logic [1:0] o_tok_ep,
  output logic       o_tok_setup,
  output logic       o_in_done
);
  initial {o_tok_valid, o_tok_addr, o_tok_ep, o_tok_setup, o_in_done} = '0;
  // one-cycle token, k0 setup, k1 acked IN; fields garbled after, not held
  task automatic tok(logic [6:0] a, logic [1:0] e, logic [1:0] k);
    @(posedge i_mclk);
    {o_tok_valid, o_tok_addr, o_tok_ep, o_tok_setup, o_in_done} <=
      {1'b1, a, e, k[0], k[1]};
    @(posedge i_mclk);
    {o_tok_valid, o_tok_addr, o_tok_ep, o_tok_setup, o_in_done} <=
      {1'b0, ~a, ~e, 2'b00};
  endtask
endmodule

// *** verification/testbench.sv ***
// testbench: bus, token, interrupt and halt scenarios
`timescale 1ns/1ps
module testbench;
  logic        i_mclk, i_rst, i_read, i_write, i_bus_reset, i_stack_full;
  logic [5:0]  i_address;
  logic [31:0] i_writedata, o_readdata;
  logic        o_waitrequest, o_irq, o_fifo_sel_valid, o_bus_clock_gate;
  logic        i_tok_valid, i_tok_setup, i_in_done, o_tok_accept;
  logic [6:0]  i_tok_addr, o_active_addr;
  logic [1:0]  i_tok_ep;
  logic [2:0]  o_fifo_sel;
  logic [3:0]  o_endpoint_halt_bits;
  logic        o_deep_suspend_power_save, o_pll_core_clock_select;
  logic        o_crystal_rate_select, o_dplus_resistor_connect;
  logic        o_remote_wake_allow;
  logic [3:0]  i_byteenable;
  logic [7:0]  v;
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          check_count = 0;
  usr_sie_regs usr_sie_regs_inst (.i_mclk, .i_rst, .i_address, .i_read,
    .i_write, .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .i_tok_valid, .i_tok_addr, .i_tok_ep, .i_tok_setup, .i_in_done,
    .i_bus_reset, .i_stack_full, .o_irq, .o_tok_accept, .o_active_addr,
    .o_fifo_sel, .o_fifo_sel_valid, .o_bus_clock_gate,
    .o_deep_suspend_power_save, .o_pll_core_clock_select,
    .o_crystal_rate_select, .o_dplus_resistor_connect,
    .o_remote_wake_allow, .o_endpoint_halt_bits);
  usr_host_model usr_host_model_inst (.i_mclk, .o_tok_valid(i_tok_valid),
    .o_tok_addr(i_tok_addr), .o_tok_ep(i_tok_ep), .o_tok_setup(i_tok_setup),
    .o_in_done(i_in_done));
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one access, held until waitrequest is seen low; gap edge before the next
  task automatic bus(logic w, logic [5:0] a, logic [7:0] d);
    int n;
    {i_write, i_read, i_address, i_writedata} <= {w, !w, a, 24'h0, d};
    for (n = 0; n < 50; n++) begin
      @(posedge i_mclk);
      if (!o_waitrequest) break;
    end
    if (n == 50) begin num_errors++; wrap_up(); end
    {i_write, i_read} <= 2'b00;
    @(posedge i_mclk);
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // scoreboard: each completed read against the oldest note
  always @(posedge i_mclk)
    if (i_read && !o_waitrequest) chk("readdata", o_readdata, exp_q.pop_front());
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    {i_read, i_write, i_address, i_writedata, i_bus_reset, i_stack_full} = '0;
    i_byteenable = 4'hF;
    i_rst = 1'b1;
    void'($urandom(90483));
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    // every map slot and the unmapped hole read zero after reset
    for (int k = 0; k < 8; k++) rd(6'(k * 4), 32'h0);
    // random control bytes read back and decode to outputs
    repeat (4) begin
      v = 8'($urandom) & 8'hEF;
      bus(1'b1, 6'h04, v);
      rd(6'h04, {24'h0, v});
      chk("fifo_sel", o_fifo_sel, v[2:0]);
      chk("clk_gate", o_bus_clock_gate, v[3]);
      chk("sel_valid", o_fifo_sel_valid, v[2:0] <= 3'h3);
      chk("suspend", o_deep_suspend_power_save, 1'b0);
      chk("pll_sel", o_pll_core_clock_select, v[5]);
      chk("xtal_sel", o_crystal_rate_select, v[6]);
      chk("pull_up", o_dplus_resistor_connect, v[7]);
    end
    // a write with the low lane disabled is dropped
    i_byteenable <= 4'h0;
    bus(1'b1, 6'h04, ~v);
    i_byteenable <= 4'hF;
    rd(6'h04, {24'h0, v});
    bus(1'b1, 6'h08, 8'hA7);
    chk("wake", o_remote_wake_allow, 1'b1);
    rd(6'h18, 32'h53);
    bus(1'b1, 6'h10, 8'h0F);
    // a stranger and then us on each endpoint; only ours flag
    for (int e = 0; e < 4; e++) begin
      usr_host_model_inst.tok(7'h12, 2'(e), 2'b00);
      usr_host_model_inst.tok(7'h53, 2'(e), 2'b00);
    end
    rd(6'h00, 32'h0F);
    chk("irq_on", o_irq, 1'b1);
    i_stack_full <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk("irq_full", o_irq, 1'b0);
    i_stack_full <= 1'b0;
    bus(1'b1, 6'h00, 8'h00);
    rd(6'h00, 32'h0);
    chk("irq_off", o_irq, 1'b0);
    // deferred update waits for an acknowledged IN read
    bus(1'b1, 6'h14, 8'h01);
    bus(1'b1, 6'h08, 8'h20);
    rd(6'h18, 32'h53);
    usr_host_model_inst.tok(7'h53, 2'd1, 2'b10);
    rd(6'h18, 32'h10);
    // halts: setup clears endpoint 0, bus reset clears the rest
    bus(1'b1, 6'h0C, 8'h0F);
    usr_host_model_inst.tok(7'h10, 2'd0, 2'b01);
    rd(6'h0C, 32'h0E);
    chk("halts", o_endpoint_halt_bits, 4'hE);
    i_bus_reset <= 1'b1;
    @(posedge i_mclk);
    i_bus_reset <= 1'b0;
    rd(6'h0C, 32'h0);
    wrap_up();
  end
endmodule
